/* File: logic/timer_pwm_pkg.sv */
package timer_pwm_pkg;

  // ---------------------------------------------------------------
  // widths and reset values
  // ---------------------------------------------------------------
  localparam int          CNT_W       = 16;
  localparam int          PRESC_W     = 3;
  localparam int          PRESC_MAX   = 7;
  localparam logic [15:0] CNT_RST     = 16'h0000;
  localparam logic [15:0] MOD_RST     = 16'hFFFF;
  localparam logic [15:0] CMP_RST     = 16'h0000;
  localparam logic [7:0]  MOD_HI_RST  = 8'hFF;
  localparam logic [7:0]  MOD_LO_RST  = 8'hFF;

  // ---------------------------------------------------------------
  // channel modes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CH_OFF     = 2'b00,
    CH_CAPTURE = 2'b01,
    CH_COMPARE = 2'b10,
    CH_PWM     = 2'b11
  } ch_mode_t;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic             run;
    logic             modulo_en;
    logic [2:0]       presc_sel;
    logic             ext_clk_sel;
    logic [7:0]       modulo_limit_high;
    logic [7:0]       modulo_limit_low;
    ch_mode_t [1:0]   ch_mode;
    logic [1:0][15:0] ch_cmp;
  } timer_cfg_t;

  typedef struct packed {
    logic [15:0]      count;
    logic             overflow;
    logic [1:0]       ch_event;
    logic [1:0][15:0] ch_capture;
    logic             pin_out;
    logic             pin_oe;
  } timer_stat_t;

endpackage

/* File: logic/dual_timer_pwm_unit.sv */
// Functional notes
// - 16-bit counter, free or modulo up
// - counter is capture and compare time base
// - modulo limit high/low bytes set terminal count
// - counter reads never disturb counting
// - both channels see the same pin input
// - limit 255, prescale 0 gives 256 clocks
// - compare value sets pulse width
// - 8-bit width in 256 steps
// - unbuffered PWM, width overwritten in place
// - late width write skips that period's compare
// - two instances, shared pins, external clock pin
`timescale 1ns/100ps
`default_nettype none

module timer_core #(
  parameter int CNT_W = timer_pwm_pkg::CNT_W
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     ext_tick,
  input  wire logic                     pin_in,
  input  wire timer_pwm_pkg::timer_cfg_t cfg,
  output var  timer_pwm_pkg::timer_stat_t stat
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [6:0]  presc;
    logic [15:0] count;
    logic        pin_prev;
    timer_pwm_pkg::timer_stat_t st;
  } core_state_t;

  core_state_t s_q;
  core_state_t s_d;

  if (CNT_W != 16) begin : g_width_chk
    $error("timer_core supports a 16-bit count only");
  end
  logic [15:0] limit;
  logic        tick;
  logic        at_limit;

  function automatic logic presc_tick(input logic [6:0] p, input logic [2:0] sel);
    logic [7:0] mask;
    mask = 8'(8'h01 << sel) - 8'h01;
    presc_tick = ((8'({1'b0, p}) & mask) == mask);
  endfunction

  always_comb begin
    limit    = {cfg.modulo_limit_high, cfg.modulo_limit_low};
    tick     = cfg.run & (cfg.ext_clk_sel ? ext_tick : presc_tick(s_q.presc, cfg.presc_sel));
    at_limit = cfg.modulo_en ? (s_q.count == limit) : (s_q.count == 16'hFFFF);
    s_d = s_q;
    s_d.st.overflow = 1'b0;
    s_d.st.ch_event = 2'b00;
    s_d.pin_prev    = pin_in;
    if (cfg.run) begin
      s_d.presc = s_q.presc + 7'h01;
    end else begin
      s_d.presc = 7'h00;
    end
    if (tick) begin
      if (at_limit) begin
        s_d.count       = timer_pwm_pkg::CNT_RST;
        s_d.st.overflow = 1'b1;
      end else begin
        s_d.count = s_q.count + 16'h0001;
      end
    end
    for (int i = 0; i < 2; i++) begin
      unique case (cfg.ch_mode[i])
        timer_pwm_pkg::CH_OFF: begin
        end
        timer_pwm_pkg::CH_CAPTURE: begin
          if (pin_in & ~s_q.pin_prev) begin
            s_d.st.ch_capture[i] = s_q.count;
            s_d.st.ch_event[i]   = 1'b1;
          end
        end
        timer_pwm_pkg::CH_COMPARE: begin
          if (tick && s_q.count == cfg.ch_cmp[i]) begin
            s_d.st.pin_out     = ~s_q.st.pin_out;
            s_d.st.ch_event[i] = 1'b1;
          end
        end
        timer_pwm_pkg::CH_PWM: begin
          if (tick && at_limit) begin
            s_d.st.pin_out = 1'b1;
          end else if (tick && s_d.count == cfg.ch_cmp[i]) begin
            s_d.st.pin_out     = 1'b0;
            s_d.st.ch_event[i] = 1'b1;
          end
        end
      endcase
    end
    s_d.st.pin_oe = (cfg.ch_mode[0][1] | cfg.ch_mode[1][1]);
    s_d.st.count  = s_d.count;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign stat = s_q.st;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_wrap;
    @(posedge clk) disable iff (rst)
      (tick && at_limit) |=> (s_q.count == 16'h0000 && s_q.st.overflow);
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap");

  property p_mod_bound;
    @(posedge clk) disable iff (rst)
      (cfg.modulo_en && $stable(limit) && s_q.count <= limit) |=> (s_q.count <= limit);
  endproperty
  a_mod_bound: assert property (p_mod_bound) else $error("count above limit");

  property p_inc;
    @(posedge clk) disable iff (rst)
      (tick && !at_limit) |=> (s_q.count == $past(s_q.count) + 16'h0001);
  endproperty
  a_inc: assert property (p_inc) else $error("count not incremented");

  property p_hold;
    @(posedge clk) disable iff (rst) !tick |=> $stable(s_q.count);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved without tick");

  property p_pwm_set;
    @(posedge clk) disable iff (rst)
      (cfg.ch_mode[0] == timer_pwm_pkg::CH_PWM && tick && at_limit) |=> s_q.st.pin_out;
  endproperty
  a_pwm_set: assert property (p_pwm_set) else $error("pwm not set at overflow");

  property p_pwm_clr;
    @(posedge clk) disable iff (rst)
      (cfg.ch_mode[0] == timer_pwm_pkg::CH_PWM && !cfg.ch_mode[1][1] && tick && !at_limit
       && (s_q.count + 16'h0001) == cfg.ch_cmp[0]) |=> !s_q.st.pin_out;
  endproperty
  a_pwm_clr: assert property (p_pwm_clr) else $error("pwm not cleared at compare");

  property p_cap;
    @(posedge clk) disable iff (rst)
      (cfg.ch_mode == {2{timer_pwm_pkg::CH_CAPTURE}} && pin_in && !s_q.pin_prev)
      |=> (s_q.st.ch_capture[0] == s_q.st.ch_capture[1] && s_q.st.ch_event == 2'b11);
  endproperty
  a_cap: assert property (p_cap) else $error("channels captured apart");

  property p_period;
    @(posedge clk) disable iff (rst)
      (cfg.run && !cfg.ext_clk_sel && cfg.presc_sel == 3'h0 && cfg.modulo_en
       && limit == 16'h00FF && s_q.st.overflow) |-> ##256 (s_q.st.overflow || !$stable(cfg));
  endproperty
  a_period: assert property (p_period) else $error("period not 256 clocks");

endmodule

module dual_timer_pwm_unit (
  input  wire logic                       SYS_CLK,
  input  wire logic                       SYS_RST,
  input  wire logic                       EXTERNAL_TIMER_CLOCK_PIN,
  input  wire logic                       FIRST_TIMER_CHANNEL_PIN_I,
  input  wire logic                       SECOND_TIMER_CHANNEL_PIN_I,
  input  wire timer_pwm_pkg::timer_cfg_t  FIRST_TIMER_INSTANCE_CFG,
  input  wire timer_pwm_pkg::timer_cfg_t  SECOND_TIMER_INSTANCE_CFG,
  output var  timer_pwm_pkg::timer_stat_t FIRST_TIMER_INSTANCE_STAT,
  output var  timer_pwm_pkg::timer_stat_t SECOND_TIMER_INSTANCE_STAT,
  output var  logic                       FIRST_TIMER_CHANNEL_PIN_O,
  output var  logic                       FIRST_TIMER_CHANNEL_PIN_OE,
  output var  logic                       SECOND_TIMER_CHANNEL_PIN_O,
  output var  logic                       SECOND_TIMER_CHANNEL_PIN_OE
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic       clk_prev_q;
  logic       ext_tick;

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      sync1_q    <= 3'h0;
      sync2_q    <= 3'h0;
      clk_prev_q <= 1'b0;
    end else begin
      sync1_q    <= {SECOND_TIMER_CHANNEL_PIN_I, FIRST_TIMER_CHANNEL_PIN_I,
                     EXTERNAL_TIMER_CLOCK_PIN};
      sync2_q    <= sync1_q;
      clk_prev_q <= sync2_q[0];
    end
  end

  assign ext_tick = sync2_q[0] & ~clk_prev_q;

  // ---------------------------------------------------------------
  // two instances
  // ---------------------------------------------------------------
  timer_pwm_pkg::timer_cfg_t second_cfg;

  always_comb begin
    second_cfg             = SECOND_TIMER_INSTANCE_CFG;
    second_cfg.ext_clk_sel = 1'b0;
  end

  timer_core u_first (
    .clk      (SYS_CLK),
    .rst      (SYS_RST),
    .ext_tick (ext_tick),
    .pin_in   (sync2_q[1]),
    .cfg      (FIRST_TIMER_INSTANCE_CFG),
    .stat     (FIRST_TIMER_INSTANCE_STAT)
  );

  timer_core u_second (
    .clk      (SYS_CLK),
    .rst      (SYS_RST),
    .ext_tick (1'b0),
    .pin_in   (sync2_q[2]),
    .cfg      (second_cfg),
    .stat     (SECOND_TIMER_INSTANCE_STAT)
  );

  assign FIRST_TIMER_CHANNEL_PIN_O   = FIRST_TIMER_INSTANCE_STAT.pin_out;
  assign FIRST_TIMER_CHANNEL_PIN_OE  = FIRST_TIMER_INSTANCE_STAT.pin_oe;
  assign SECOND_TIMER_CHANNEL_PIN_O  = SECOND_TIMER_INSTANCE_STAT.pin_out;
  assign SECOND_TIMER_CHANNEL_PIN_OE = SECOND_TIMER_INSTANCE_STAT.pin_oe;

endmodule

`default_nettype wire

/* File: verification/pin_source_model.sv */
`timescale 1ns/100ps
`default_nettype none

// ---------------------------------------------------------------
// capture signal source on the shared channel pin
// ---------------------------------------------------------------
module pin_source_model (
  input  wire logic clk,
  input  wire logic fire,
  output var  logic level
);
  // one rising edge per request, held high for capture
  initial level = 1'b0;
  always @(posedge clk) begin
    if (fire) begin
      level <= #3 1'b1;
      level <= #200 1'b0;
    end
  end
endmodule

`default_nettype wire

/* File: verification/dual_timer_pwm_unit_test.sv */
`timescale 1ns/100ps
`default_nettype none

module dual_timer_pwm_unit_test;
  logic                       clk;
  logic                       rst;
  logic                       ext_clk;
  logic                       fire;
  logic                       src2;
  logic                       p1_o;
  logic                       p1_oe;
  logic                       p2_o;
  logic                       p2_oe;
  timer_pwm_pkg::timer_cfg_t  cfg1;
  timer_pwm_pkg::timer_cfg_t  cfg2;
  timer_pwm_pkg::timer_stat_t st1;
  timer_pwm_pkg::timer_stat_t st2;
  int                         fails;
  int                         checked;
  int                         n;
  logic [15:0]                c0;
  logic [15:0]                c2;

  // ---------------------------------------------------------------
  // clock, partner, design
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  pin_source_model SRC (.clk(clk), .fire(fire), .level(src2));

  dual_timer_pwm_unit DUT (
    .SYS_CLK(clk), .SYS_RST(rst), .EXTERNAL_TIMER_CLOCK_PIN(ext_clk),
    .FIRST_TIMER_CHANNEL_PIN_I(p1_oe ? p1_o : 1'b0),
    .SECOND_TIMER_CHANNEL_PIN_I(p2_oe ? p2_o : src2),
    .FIRST_TIMER_INSTANCE_CFG(cfg1), .SECOND_TIMER_INSTANCE_CFG(cfg2),
    .FIRST_TIMER_INSTANCE_STAT(st1), .SECOND_TIMER_INSTANCE_STAT(st2),
    .FIRST_TIMER_CHANNEL_PIN_O(p1_o), .FIRST_TIMER_CHANNEL_PIN_OE(p1_oe),
    .SECOND_TIMER_CHANNEL_PIN_O(p2_o), .SECOND_TIMER_CHANNEL_PIN_OE(p2_oe));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic step;
    @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic give_up(input int lim);
    if (n >= lim) begin
      fails++;
      test_done();
    end
  endtask

  task automatic wait_ovf;
    n = 0;
    step();
    while (st1.overflow !== 1'b1 && n < 70000) begin
      n++;
      step();
    end
    give_up(70000);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic free_count;
    cfg1.run = 1'b1;
    step();
    c0 = st1.count;
    repeat (10) step();
    chk(st1.count, c0 + 16'h000A);
    wait_ovf();
    chk(st1.count, 16'h0000);
  endtask

  task automatic modulo_short;
    cfg1.modulo_en = 1'b1;
    cfg1.modulo_limit_high = 8'h00;
    cfg1.modulo_limit_low = 8'h05;
    wait_ovf();
    chk(st1.count, 16'h0000);
    wait_ovf();
    chk(16'(n + 1), 16'h0006);
  endtask

  task automatic pwm_half;
    cfg1.modulo_limit_low = 8'hFF;
    cfg1.ch_mode[0] = timer_pwm_pkg::CH_PWM;
    cfg1.ch_cmp[0] = 16'h0080;
    wait_ovf();
    wait_ovf();
    chk({15'h0000, p1_oe}, 16'h0001);
    n = 0;
    while (p1_o === 1'b1 && n < 300) begin
      n++;
      step();
    end
    give_up(300);
    chk(16'(n), 16'h0080);
    c0 = 16'(n);
    wait_ovf();
    chk(c0 + 16'(n) + 16'h0001, 16'h0100);
    chk({15'h0000, p1_o}, 16'h0001);
  endtask

  task automatic width_update;
    cfg1.ch_cmp[0] = 16'h0040;
    n = 0;
    while (p1_o === 1'b1 && n < 300) begin
      n++;
      step();
    end
    give_up(300);
    chk(16'(n), 16'h0040);
    wait_ovf();
    repeat (32) step();
    cfg1.ch_cmp[0] = 16'h0010;
    n = 0;
    while (st1.count !== 16'h00FF && n < 300) begin
      n++;
      step();
    end
    give_up(300);
    chk({15'h0000, p1_o}, 16'h0001);
    wait_ovf();
    n = 0;
    while (p1_o === 1'b1 && n < 300) begin
      n++;
      step();
    end
    give_up(300);
    chk(16'(n), 16'h0010);
  endtask

  task automatic shared_capture;
    cfg2.run = 1'b1;
    cfg2.ch_mode[0] = timer_pwm_pkg::CH_CAPTURE;
    cfg2.ch_mode[1] = timer_pwm_pkg::CH_CAPTURE;
    repeat (3) step();
    fire = 1'b1;
    step();
    c0 = st2.count;
    fire = 1'b0;
    n = 0;
    while (st2.ch_event[0] !== 1'b1 && n < 20) begin
      n++;
      step();
    end
    give_up(20);
    chk({14'h0000, st2.ch_event}, 16'h0003);
    chk(st2.ch_capture[0], c0 + 16'h0002);
    chk(st2.ch_capture[1], c0 + 16'h0002);
  endtask

  task automatic compare_toggle;
    cfg2.ch_mode[1] = timer_pwm_pkg::CH_OFF;
    cfg2.ch_mode[0] = timer_pwm_pkg::CH_COMPARE;
    cfg2.ch_cmp[0] = st2.count + 16'h0010;
    repeat (16) step();
    chk({14'h0000, p2_oe, p2_o}, 16'h0002);
    step();
    chk({14'h0000, p2_oe, p2_o}, 16'h0003);
    chk({15'h0000, st2.ch_event[0]}, 16'h0001);
  endtask

  task automatic ext_clock;
    wait_ovf();
    cfg1.modulo_en = 1'b0;
    cfg1.ext_clk_sel = 1'b1;
    cfg2.ext_clk_sel = 1'b1;
    step();
    c0 = st1.count;
    c2 = st2.count;
    repeat (4) begin
      ext_clk = 1'b1;
      repeat (2) step();
      ext_clk = 1'b0;
      repeat (2) step();
    end
    repeat (3) step();
    chk(st1.count, c0 + 16'h0004);
    chk(st2.count, c2 + 16'h0013);
    cfg1.ext_clk_sel = 1'b0;
    cfg1.presc_sel = 3'h2;
    c0 = st1.count;
    repeat (16) step();
    chk(st1.count, c0 + 16'h0004);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    fails = 0;
    checked = 0;
    rst = 1'b1;
    ext_clk = 1'b0;
    fire = 1'b0;
    cfg1 = '0;
    cfg2 = '0;
    cfg1.modulo_limit_high = timer_pwm_pkg::MOD_HI_RST;
    cfg1.modulo_limit_low = timer_pwm_pkg::MOD_LO_RST;
    cfg2.modulo_limit_high = timer_pwm_pkg::MOD_HI_RST;
    cfg2.modulo_limit_low = timer_pwm_pkg::MOD_LO_RST;
    repeat (20) step();
    rst = 1'b0;
    step();
    chk(st1.count, timer_pwm_pkg::CNT_RST);
    free_count();
    modulo_short();
    pwm_half();
    width_update();
    shared_capture();
    compare_toggle();
    ext_clock();
    test_done();
  end
endmodule

`default_nettype wire
